// ==== lptg_panel_model.sv ====
// Purpose: panel-side model that feeds pixel words and times the panel strobes
// Assumes: all polarity bits are zero while figures are taken
// Notes: figures are in core clock cycles, held until the next event
`default_nettype none
module lptg_panel_model (
  input wire logic clk_i,
  input wire logic pclk_i,
  input wire logic lsync_i,
  input wire logic fsync_i,
  input wire logic dv_i,
  input wire logic take_i,
  input wire logic [23:0] bus_i,
  output logic [23:0] pix_o = 24'h5A3C96,
  output int ls_len_o,
  output int dv_len_o,
  output int line_per_o,
  output int frame_per_o,
  output int fs_len_o,
  output int dv_lines_o,
  output int rises_o,
  output int hi_chg_o,
  output int lo_chg_o
);
  int c, ls_c, fs_c, dv_c, dvn, pr;
  logic pl, fl, vl, cl;
  logic [23:0] pb;
  always_ff @(posedge clk_i) begin
    c <= c + 1;
    {pl, fl, vl, cl} <= {lsync_i, fsync_i, dv_i, pclk_i};
    pb <= bus_i;
    // new word per take, so every pixel differs
    if (take_i) pix_o <= pix_o + 24'h101011;
    pr <= ((lsync_i && !pl) ? 0 : pr) + int'(pclk_i && !cl);
    dvn <= ((fsync_i && !fl) ? 0 : dvn) + int'(dv_i && !vl);
    if (lsync_i && !pl) begin
      line_per_o <= c - ls_c;
      ls_c <= c;
      rises_o <= pr;
    end
    if (!lsync_i && pl) ls_len_o <= c - ls_c;
    if (dv_i && !vl) dv_c <= c;
    if (!dv_i && vl) dv_len_o <= c - dv_c;
    if (fsync_i && !fl) begin
      frame_per_o <= c - fs_c;
      fs_c <= c;
      dv_lines_o <= dvn;
    end
    if (!fsync_i && fl) fs_len_o <= c - fs_c;
    // which pin phase the data moves in
    if (dv_i && vl && bus_i != pb) begin
      if (pclk_i) hi_chg_o <= hi_chg_o + 1;
      else lo_chg_o <= lo_chg_o + 1;
    end
  end
endmodule
`default_nettype wire

// ==== lptg_pkg.sv ====
// Purpose: constants and types of the panel timing generator
// Assumes: register word index times four gives the byte address
// Notes: single-clock design, classic Wishbone slave
`default_nettype none
package lptg_pkg;
  // ----------------------------------------------------------------
  // Register word indices
  // ----------------------------------------------------------------
  localparam logic [2:0] IDX_C1 = 3'h0;
  localparam logic [2:0] IDX_C2 = 3'h1;
  localparam logic [2:0] IDX_T1 = 3'h2;
  localparam logic [2:0] IDX_T2 = 3'h3;
  localparam logic [2:0] IDX_FR = 3'h4;
  localparam logic [2:0] IDX_PW = 3'h5;
  localparam logic [2:0] IDX_CC = 3'h6;
  localparam logic [2:0] IDX_CV = 3'h7;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int F_DIV = 0;
  localparam int F_BYP = 8;
  localparam int F_REDGE = 9;
  localparam int F_LCNT = 21;
  localparam int F_DTYPE = 0;
  localparam int F_DUAL = 2;
  localparam int F_IFW = 3;
  localparam int F_CRUN = 5;
  localparam int F_POL = 8;
  localparam int F_LDLY = 0;
  localparam int F_FBP = 8;
  localparam int F_FSW = 16;
  localparam int F_LSW = 0;
  localparam int F_LBP = 8;
  localparam int F_LFP = 16;
  localparam int F_FFP = 24;
  localparam int F_ALC = 0;
  localparam int F_ALL = 21;
  localparam int F_PREQ = 0;
  localparam int F_GUARD = 1;
  localparam int F_PSTAT = 31;
  localparam int F_PS = 0;
  localparam int F_CPOL = 2;
  localparam int F_CMP = 0;

  // Polarity bit order inside the polarity field
  localparam int P_PCLK = 0;
  localparam int P_LSYNC = 1;
  localparam int P_FSYNC = 2;
  localparam int P_DV = 3;
  localparam int P_PWR = 4;

  // Display types and interface widths
  localparam logic [1:0] DT_TFT = 2'h0;
  localparam logic [1:0] DT_MONO = 2'h1;
  localparam logic [1:0] DT_COLOR = 2'h2;
  localparam logic [1:0] IFW_4 = 2'h0;
  localparam logic [1:0] IFW_8 = 2'h1;
  localparam logic [1:0] IFW_16 = 2'h2;

  // ----------------------------------------------------------------
  // Writable bits and reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] WM_C1 = 32'h0000_03FF;
  localparam logic [31:0] WM_C2 = 32'h0000_1F3F;
  localparam logic [31:0] WM_T1 = 32'h003F_FFFF;
  localparam logic [31:0] WM_T2 = 32'hFFFF_FFFF;
  localparam logic [31:0] WM_FR = 32'hFFE0_07FF;
  localparam logic [31:0] WM_PW = 32'h0000_00FF;
  localparam logic [31:0] WM_CC = 32'h0000_0007;
  localparam logic [31:0] WM_CV = 32'h0000_00FF;
  localparam logic [7:0][31:0] WMASK = {WM_CV, WM_CC, WM_PW, WM_FR,
                                        WM_T2, WM_T1, WM_C2, WM_C1};
  localparam logic [31:0] RST_C1 = 32'h0000_0001;
  localparam logic [31:0] RST_C2 = 32'h0000_0000;
  localparam logic [31:0] RST_T1 = 32'h0000_0000;
  localparam logic [31:0] RST_T2 = 32'h0000_0000;
  localparam logic [31:0] RST_FR = 32'h0020_0001;
  localparam logic [31:0] RST_PW = 32'h0000_0002;
  localparam logic [31:0] RST_CC = 32'h0000_0000;
  localparam logic [31:0] RST_CV = 32'h0000_0000;
  localparam logic [7:0][31:0] RST_CFG = {RST_CV, RST_CC, RST_PW, RST_FR,
                                          RST_T2, RST_T1, RST_C2, RST_C1};

  typedef enum logic [2:0] {H_DLY, H_SYN, H_BCK, H_ACT, H_FRT} lptg_h_t;

  typedef struct packed {
    logic [7:0][31:0] cfg;
    lptg_h_t h;
    logic [10:0] hcnt;
    logic [11:0] vline;
    logic [7:0] dcnt;
    logic ph;
    logic [10:0] lcnt;
    logic pwr;
    logic [6:0] gcnt;
    logic [2:0] pre;
    logic [7:0] ccnt;
    logic ack;
    logic [31:0] dat;
    logic pclk;
    logic lsync;
    logic fsync;
    logic dv;
    logic take;
    logic ppwr;
    logic cc;
    logic [23:0] pd;
  } lptg_st_t;
endpackage
`default_nettype wire

// ==== lptg_timing.sv ====
// Purpose: panel timing generator with pixel clock, syncs, power
//   sequencing and contrast PWM, behind a classic Wishbone slave
// Assumes: pixel_data_i comes from logic on clk_i
// Notes: all outputs are registered fields of one state struct
//
// Operation
// - Pixel clock is core clock over twice divisor; bypass toggles it every core cycle.
// - Pixel data changes on falling pixel clock edge, or rising if selected.
// - Run mode picks free-running clock or clock only during valid data.
// - Line sync follows each shifted line; data valid marks valid data.
// - Line start to line sync takes line-sync delay plus one cycles.
// - Line sync lasts line-sync width plus one pixel cycles.
// - Line sync fall to first valid data takes back porch plus one.
// - After last valid data, line ends after front porch plus one.
// - STN frame sync covers the whole first line, from its first active edge.
// - TFT frame sync rises at first line, lasts width plus one lines.
// - Frame back porch inserts that many idle lines; zero for STN.
// - Frame front porch inserts that many idle lines; zero for STN.
// - Each line has active length plus one active pixel cycles.
// - Each frame has active line count plus one active lines.
// - Read-only line counter drops by one at each line sync fall.
// - Bits 12 to 8 of control two set output polarities.
// - Power changes only after the guard count of frames following request.
// - Contrast output is polarity while 8-bit counter below compare value.
// - Prescale select picks one of four contrast counter rates.
// - Display type picks TFT, STN mono or colour; scan/width limits apply.
`default_nettype none
module lptg_timing
  import lptg_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic [23:0] pixel_data_i,
  output logic pixel_take_o,
  output logic pixel_clock_o,
  output logic line_sync_o,
  output logic frame_sync_o,
  output logic data_valid_out_o,
  output logic [23:0] pixel_data_bus_o,
  output logic panel_power_o,
  output logic contrast_out_o
);
  lptg_st_t s;
  lptg_st_t n;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [7:0] a);
    return a[7:5] == 3'h0 && a[1:0] == 2'h0;
  endfunction

  function automatic logic [31:0] rd(input lptg_st_t st, input logic [2:0] i);
    logic [31:0] v;
    v = st.cfg[i];
    if (i == IDX_C1) begin
      v[F_LCNT +: 11] = st.lcnt;
    end
    if (i == IDX_PW) begin
      v[F_PSTAT] = st.pwr;
    end
    return v;
  endfunction

  // ----------------------------------------------------------------
  // Configuration fields
  // ----------------------------------------------------------------
  logic [7:0] f_div, f_ldly, f_fbp, f_lsw, f_lbp, f_lfp, f_ffp, f_cmp;
  logic [5:0] f_fsw;
  logic [4:0] f_pol;
  logic [1:0] f_dtype, f_ifw, f_ps;
  logic [10:0] f_alc, f_all;
  logic [6:0] f_guard;
  logic f_byp, f_redge, f_dual, f_crun, f_preq, f_cpol;
  assign f_div = s.cfg[IDX_C1][F_DIV +: 8];
  assign f_byp = s.cfg[IDX_C1][F_BYP];
  assign f_redge = s.cfg[IDX_C1][F_REDGE];
  assign f_dtype = s.cfg[IDX_C2][F_DTYPE +: 2];
  assign f_dual = s.cfg[IDX_C2][F_DUAL];
  assign f_ifw = s.cfg[IDX_C2][F_IFW +: 2];
  assign f_crun = s.cfg[IDX_C2][F_CRUN];
  assign f_pol = s.cfg[IDX_C2][F_POL +: 5];
  assign f_ldly = s.cfg[IDX_T1][F_LDLY +: 8];
  assign f_fbp = s.cfg[IDX_T1][F_FBP +: 8];
  assign f_fsw = s.cfg[IDX_T1][F_FSW +: 6];
  assign f_lsw = s.cfg[IDX_T2][F_LSW +: 8];
  assign f_lbp = s.cfg[IDX_T2][F_LBP +: 8];
  assign f_lfp = s.cfg[IDX_T2][F_LFP +: 8];
  assign f_ffp = s.cfg[IDX_T2][F_FFP +: 8];
  assign f_alc = s.cfg[IDX_FR][F_ALC +: 11];
  assign f_all = s.cfg[IDX_FR][F_ALL +: 11];
  assign f_preq = s.cfg[IDX_PW][F_PREQ];
  assign f_guard = s.cfg[IDX_PW][F_GUARD +: 7];
  assign f_ps = s.cfg[IDX_CC][F_PS +: 2];
  assign f_cpol = s.cfg[IDX_CC][F_CPOL];
  assign f_cmp = s.cfg[IDX_CV][F_CMP +: 8];

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [7:0] div;
    logic [10:0] lim;
    logic [11:0] vlast, vfirst;
    logic [23:0] dmask;
    logic [2:0] pmask;
    logic rise, fall, run, lend, fend, tft, dual, wr, en, act, fs_lvl;
    logic dv_lvl, dedge, pchg;
    logic [1:0] ifw;
    div = 8'h00;
    lim = 11'h000;
    vlast = 12'h000;
    vfirst = 12'h000;
    dmask = 24'h00_0000;
    pmask = 3'h0;
    rise = 1'b0;
    fall = 1'b0;
    lend = 1'b0;
    fend = 1'b0;
    fs_lvl = 1'b0;
    run = 1'b0;
    tft = 1'b0;
    dual = 1'b0;
    wr = 1'b0;
    en = 1'b0;
    act = 1'b0;
    dv_lvl = 1'b0;
    dedge = 1'b0;
    pchg = 1'b0;
    ifw = 2'h0;
    n = s;

    // --------------------------------------------------------------
    // Bus access
    // --------------------------------------------------------------
    // Wishbone: ack one cycle after the request, write at the ack edge
    wr = cyc_i & stb_i & we_i & s.ack & hit(adr_i);
    n.ack = cyc_i & stb_i & ~s.ack;
    n.dat = (cyc_i & stb_i & ~s.ack & hit(adr_i)) ? rd(s, adr_i[4:2]) : 32'h0000_0000;
    if (wr) begin
      for (int b = 0; b < 4; b++) begin
        if (sel_i[b]) begin
          n.cfg[adr_i[4:2]][b*8 +: 8] = (dat_i[b*8 +: 8] & WMASK[adr_i[4:2]][b*8 +: 8])
            | (s.cfg[adr_i[4:2]][b*8 +: 8] & ~WMASK[adr_i[4:2]][b*8 +: 8]);
        end
      end
    end


    // --------------------------------------------------------------
    // Panel type
    // --------------------------------------------------------------
    // type limits
    tft = f_dtype != DT_MONO && f_dtype != DT_COLOR;
    dual = f_dual & ~tft;
    ifw = f_ifw;
    if (!dual && ifw != IFW_4) begin
      ifw = IFW_8;
    end
    if (dual && ifw != IFW_16) begin
      ifw = IFW_8;
    end
    // Unused data lines held low, so the panel sees no stray toggles
    if (tft) begin
      dmask = 24'hFF_FFFF;
    end else if (ifw == IFW_4) begin
      dmask = 24'h00_000F;
    end else if (ifw == IFW_8) begin
      dmask = 24'h00_00FF;
    end else begin
      dmask = 24'h00_FFFF;
    end


    // --------------------------------------------------------------
    // Pixel clock divider
    // --------------------------------------------------------------
    // Timing runs while powered or while a power change waits its guard
    run = s.pwr | f_preq;
    // Divisor 0 would stall the clock, so it counts as 1
    div = (f_div == 8'h00) ? 8'h01 : f_div;
    if (!run) begin
      n.dcnt = 8'h00;
      n.ph = 1'b0;
      n.h = H_DLY;
      n.hcnt = 11'h000;
      n.vline = 12'h000;
      n.lcnt = f_alc;
    end else if (f_byp) begin
      rise = 1'b1;
      fall = 1'b1;
      n.ph = ~s.ph;
    end else if (s.dcnt == div - 8'h01) begin
      n.dcnt = 8'h00;
      n.ph = ~s.ph;
      rise = ~s.ph;
      fall = s.ph;
    end else begin
      n.dcnt = s.dcnt + 8'h01;
    end


    // --------------------------------------------------------------
    // Horizontal sequence
    // --------------------------------------------------------------
    // One step per pixel clock rise
    case (s.h)
      H_DLY: lim = {3'h0, f_ldly};
      H_SYN: lim = {3'h0, f_lsw};
      H_BCK: lim = {3'h0, f_lbp};
      H_ACT: lim = f_all;
      H_FRT: lim = {3'h0, f_lfp};
      default: lim = 11'h000;
    endcase
    vlast = {4'h0, f_fbp} + {1'b0, f_alc} + {4'h0, f_ffp};
    if (rise) begin
      if (s.hcnt == lim) begin
        n.hcnt = 11'h000;
        case (s.h)
          H_DLY: n.h = H_SYN;
          H_SYN: begin
            n.h = H_BCK;
            n.lcnt = s.lcnt - 11'h001;
          end
          H_BCK: n.h = H_ACT;
          H_ACT: n.h = H_FRT;
          H_FRT: begin
            n.h = H_DLY;
            lend = 1'b1;
          end
          default: n.h = H_DLY;
        endcase
      end else begin
        n.hcnt = s.hcnt + 11'h001;
      end
    end

    // --------------------------------------------------------------
    // Vertical sequence
    // --------------------------------------------------------------
    // vertical line sequence
    if (lend) begin
      if (s.vline == vlast) begin
        n.vline = 12'h000;
        fend = 1'b1;
        n.lcnt = f_alc;
      end else begin
        n.vline = s.vline + 12'h001;
      end
    end


    // --------------------------------------------------------------
    // Power sequencing
    // --------------------------------------------------------------
    // guard frames before power follows the request
    pchg = 1'b0;
    if (wr && adr_i[4:2] == IDX_PW) begin
      n.gcnt = 7'h00;
    end else if (f_preq != s.pwr) begin
      if (f_guard == 7'h00) begin
        pchg = 1'b1;
      end else if (fend) begin
        if (s.gcnt + 7'h01 >= f_guard) begin
          pchg = 1'b1;
        end else begin
          n.gcnt = s.gcnt + 7'h01;
        end
      end
    end
    if (pchg) begin
      n.pwr = f_preq;
      n.gcnt = 7'h00;
    end


    // --------------------------------------------------------------
    // Output levels
    // --------------------------------------------------------------
    // Taken from the next state, so pins line up with what they show
    en = n.pwr;
    vfirst = {4'h0, f_fbp};
    act = n.vline >= vfirst && n.vline <= vfirst + {1'b0, f_alc};
    dv_lvl = en & n.h == H_ACT & act;
    if (tft) begin
      // sync for width plus one lines
      fs_lvl = en & n.vline <= {6'h00, f_fsw};
    end else begin
      // whole first line from its first active edge
      fs_lvl = en & ((n.vline == vfirst & (n.h == H_ACT | n.h == H_FRT))
        | (n.vline == vfirst + 12'h001 & n.h != H_ACT & n.h != H_FRT));
    end
    n.lsync = (en & n.h == H_SYN) ^ f_pol[P_LSYNC];
    n.dv = dv_lvl ^ f_pol[P_DV];
    n.fsync = fs_lvl ^ f_pol[P_FSYNC];
    n.ppwr = en ^ f_pol[P_PWR];
    // gated clock only during valid data
    n.pclk = (en & n.ph & (~f_crun | dv_lvl)) ^ f_pol[P_PCLK];

    dedge = f_redge ? rise : fall;
    n.take = dedge & dv_lvl;
    if (!en) begin
      n.pd = 24'h00_0000;
    end else if (dedge & dv_lvl) begin
      n.pd = pixel_data_i & dmask;
    end


    // --------------------------------------------------------------
    // Contrast PWM
    // --------------------------------------------------------------
    // prescale taps of 1, 2, 4 and 8 cycles
    case (f_ps)
      2'h0: pmask = 3'h0;
      2'h1: pmask = 3'h1;
      2'h2: pmask = 3'h3;
      default: pmask = 3'h7;
    endcase
    n.pre = s.pre + 3'h1;
    if ((s.pre & pmask) == 3'h0) begin
      n.ccnt = s.ccnt + 8'h01;
    end
    n.cc = (s.ccnt < f_cmp) ? f_cpol : ~f_cpol;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
      s.cfg <= RST_CFG;
    end else begin
      s <= n;
    end
  end

  assign dat_o = s.dat;
  assign ack_o = s.ack;
  assign pixel_take_o = s.take;
  assign pixel_clock_o = s.pclk;
  assign line_sync_o = s.lsync;
  assign frame_sync_o = s.fsync;
  assign data_valid_out_o = s.dv;
  assign pixel_data_bus_o = s.pd;
  assign panel_power_o = s.ppwr;
  assign contrast_out_o = s.cc;
endmodule
`default_nettype wire

// ==== lptg_timing_chk.sv ====
// Purpose: port-level checks of the panel timing generator
// Assumes: whole-word writes, bypass never set
// Notes: configuration is shadowed by snooping bus writes
`default_nettype none
module lptg_timing_chk
  import lptg_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic pixel_clock_o,
  input wire logic line_sync_o,
  input wire logic frame_sync_o,
  input wire logic data_valid_out_o,
  input wire logic panel_power_o,
  input wire logic contrast_out_o
);
  logic [7:0] div, lsw, cv;
  logic [10:0] len;
  logic [4:0] output_polarity;
  logic runm, cpol, pc_seen, wr, pwr, ls_act, dv_act;
  logic [1:0] q;
  logic [15:0] ls_n, dv_n, pc_n, per;
  assign wr = ack_o & cyc_i & stb_i & we_i & (adr_i[7:5] == 3'h0) & (adr_i[1:0] == 2'h0);
  assign pwr = panel_power_o ^ output_polarity[P_PWR];
  assign ls_act = line_sync_o ^ output_polarity[P_LSYNC];
  assign dv_act = data_valid_out_o ^ output_polarity[P_DV];
  assign per = (div == 8'h00) ? 16'h0001 : {8'h00, div};
  always_ff @(posedge clk_i) begin
    ls_n <= ls_act ? ls_n + 16'h1 : 16'h0;
    dv_n <= dv_act ? dv_n + 16'h1 : 16'h0;
    pc_n <= $changed(pixel_clock_o) ? 16'h1 : pc_n + 16'h1;
    pc_seen <= pwr & !runm & (pc_seen | $changed(pixel_clock_o));
    if (rst_i) begin
      {div, lsw, len, output_polarity, runm, cv, cpol, q} <= {8'h01, 8'h00, 11'h001, 5'h00, 1'b0, 8'h00, 1'b0, 2'h0};
    end else if (wr) begin
      q <= 2'h0;
      case (adr_i[4:2])
        IDX_C1: div <= dat_i[7:0];
        IDX_C2: {runm, output_polarity} <= {dat_i[F_CRUN], dat_i[12:8]};
        IDX_T2: lsw <= dat_i[7:0];
        IDX_FR: len <= dat_i[31:21];
        IDX_CC: cpol <= dat_i[F_CPOL];
        IDX_CV: cv <= dat_i[7:0];
        default: ;
      endcase
    end else if (q != 2'h3) begin
      q <= q + 2'h1;
    end
  end
  a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o) else $error("ack longer than one cycle");
  a_ack_answer: assert property (@(posedge clk_i) disable iff (rst_i)
    cyc_i && stb_i && !ack_o |=> ack_o) else $error("request not answered");
  a_unmapped_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o && !we_i && adr_i[7:5] != 3'h0 |-> dat_o == 32'h0) else $error("unmapped read");
  a_line_width: assert property (@(posedge clk_i) disable iff (rst_i)
    pwr && $stable(output_polarity) && $fell(ls_act) |-> ls_n == ((16'(lsw) + 16'h1) * per) << 1)
    else $error("line sync width");
  a_valid_len: assert property (@(posedge clk_i) disable iff (rst_i)
    pwr && $stable(output_polarity) && $fell(dv_act) |-> dv_n == ((16'(len) + 16'h1) * per) << 1)
    else $error("data valid length");
  a_pclk_rate: assert property (@(posedge clk_i) disable iff (rst_i)
    pc_seen && $changed(pixel_clock_o) |-> pc_n == per) else $error("pixel clock rate");
  a_power_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    q == 2'h3 && !pwr && !$past(pwr) |-> {pixel_clock_o, line_sync_o, frame_sync_o,
    data_valid_out_o} == {output_polarity[0], output_polarity[1], output_polarity[2], output_polarity[3]}) else $error("idle outputs");
  a_contrast_off: assert property (@(posedge clk_i) disable iff (rst_i)
    q == 2'h3 && cv == 8'h00 |-> contrast_out_o == !cpol) else $error("contrast at zero");
endmodule
bind lptg_timing lptg_timing_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
  .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
  .ack_o(ack_o), .pixel_clock_o(pixel_clock_o), .line_sync_o(line_sync_o),
  .frame_sync_o(frame_sync_o), .data_valid_out_o(data_valid_out_o),
  .panel_power_o(panel_power_o), .contrast_out_o(contrast_out_o));
`default_nettype wire

// ==== lptg_timing_tb.sv ====
// Purpose: self-checking bench of the panel timing generator
// Assumes: TFT panel, divisor 2, so one pixel period is 4 core cycles
// Notes: timing is reprogrammed only while panel power is off
`default_nettype none
module lptg_timing_tb;
  import lptg_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, take, pclk, ls, fs, dv, pwr, cc;
  logic [7:0] adr_i;
  logic [3:0] sel_i;
  logic [31:0] dat_i, dat_o, h, q;
  logic [23:0] pix, bus;
  int bad_count, checked, ls_len, dv_len, line_per, frame_per, fs_len, dv_lines, rises,
    hi_chg, lo_chg, lo0;
  lptg_timing uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .pixel_data_i(pix), .pixel_take_o(take), .pixel_clock_o(pclk), .line_sync_o(ls),
    .frame_sync_o(fs), .data_valid_out_o(dv), .pixel_data_bus_o(bus),
    .panel_power_o(pwr), .contrast_out_o(cc));
  lptg_panel_model panel (.clk_i(clk_i), .pclk_i(pclk), .lsync_i(ls), .fsync_i(fs),
    .dv_i(dv), .take_i(take), .bus_i(bus), .pix_o(pix), .ls_len_o(ls_len),
    .dv_len_o(dv_len), .line_per_o(line_per), .frame_per_o(frame_per), .fs_len_o(fs_len),
    .dv_lines_o(dv_lines), .rises_o(rises), .hi_chg_o(hi_chg), .lo_chg_o(lo_chg));
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic ck(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 100);
    q = dat_o;
    {cyc_i, stb_i, we_i} <= 3'b000;
    if (n >= 100) ck(32'h0, 32'h1);
  endtask
  function automatic logic sg(input int s);
    case (s)
      0: return pwr;
      1: return fs;
      2: return !ls;
      default: return !pwr;
    endcase
  endfunction
  // Bounded wait for a rising edge of the picked condition
  task automatic till(input int s);
    int n;
    n = 0;
    while (sg(s) === 1'b1 && n < 3000) begin
      @(posedge clk_i);
      n++;
    end
    while (sg(s) !== 1'b1 && n < 3000) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 3000) ck(32'(s), 32'hFFFF);
  endtask
  task automatic run_check(input int rs);
    wb(1'b1, 8'h14, 32'h3);
    till(0);
    repeat (3) till(1);
    ck(ls_len, 32'd12);
    ck(dv_len, 32'd24);
    ck(line_per, 32'd56);
    ck(frame_per, 32'd280);
    ck(dv_lines, 32'd3);
    ck(fs_len, 32'd56);
    ck(rises, 32'(rs));
  endtask
  initial begin
    {rst_i, cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} = {4'b1000, 8'h00, 4'hF, 32'h0};
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b1, 8'h20, 32'hFFFFFFFF);
    wb(1'b0, 8'h20, 32'h0);
    ck(q, 32'h0);
    for (int i = 0; i < 8; i++) begin
      wb(1'b0, 8'(i * 4), 32'h0);
      ck(q, RST_CFG[i] | (i == 0 ? 32'h00200000 : 32'h0));
    end
    wb(1'b1, 8'h14, 32'h80000002);
    wb(1'b0, 8'h14, 32'h0);
    ck(q, 32'h2);
    $display("test registers done");
    wb(1'b1, 8'h04, 32'h1F00);
    repeat (4) @(posedge clk_i);
    ck({27'h0, pwr, dv, fs, ls, pclk}, 32'h1F);
    wb(1'b1, 8'h04, 32'h0);
    wb(1'b1, 8'h1C, 32'h40);
    for (int ps = 0; ps < 5; ps++) begin
      wb(1'b1, 8'h18, ps < 4 ? 32'(ps) | 32'h4 : 32'h0);
      repeat (3) @(posedge clk_i);
      h = 0;
      for (int k = 0; k < (256 << (ps & 3)); k++) begin
        @(posedge clk_i);
        h += 32'(cc);
      end
      ck(h, ps < 4 ? 32'h40 << ps : 32'hC0);
    end
    $display("test contrast done");
    wb(1'b1, 8'h00, 32'h2);
    wb(1'b1, 8'h08, 32'h0101);
    wb(1'b1, 8'h0C, 32'h01000102);
    wb(1'b1, 8'h10, 32'h00A00002);
    run_check(14);
    ck(hi_chg, 32'h0);
    ck(32'(lo_chg > 0), 32'h1);
    till(1);
    till(2);
    wb(1'b0, 8'h00, 32'h0);
    ck(q, 32'h00200002);
    till(2);
    wb(1'b0, 8'h00, 32'h0);
    ck(q, 32'h00000002);
    $display("test free clock done");
    wb(1'b1, 8'h14, 32'h4);
    repeat (250) @(posedge clk_i);
    ck(32'(pwr), 32'h1);
    till(3);
    $display("test power guard done");
    lo0 = lo_chg;
    wb(1'b1, 8'h04, 32'h20);
    wb(1'b1, 8'h00, 32'h202);
    run_check(6);
    ck(32'(hi_chg > 0), 32'h1);
    ck(32'(lo_chg), 32'(lo0));
    $display("test gated clock done");
    final_report();
  end
  initial begin
    repeat (60000) @(posedge clk_i);
    bad_count++;
    final_report();
  end
endmodule
`default_nettype wire
